// ---- design/odl_pkg.sv ----
package odl_pkg;
	localparam int ODL_ADDR_W = 3;
	localparam int ODL_DATA_W = 8;
	localparam int ODL_WORD_W = 11;
	localparam int ODL_NCH = 8;
	localparam int ODL_ADDR_HI = 10;
	localparam int ODL_ADDR_LO = 8;
	localparam int ODL_DATA_HI = 7;
	localparam int ODL_DATA_LO = 0;
	localparam logic [7:0] ODL_MIDSCALE = 8'h80;
	localparam int ODL_MCLK_HZ = 10000000;
	localparam int ODL_SYNC_STAGES = 3;
endpackage

// ---- design/odl_sync.sv ----
`timescale 1ns/1ps
// Three-stage pin synchroniser; output valid once stages two and three agree
module odl_sync (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic [2:0] st;
		logic lvl;
	} odl_sync_s;
	odl_sync_s s_q;
	odl_sync_s s_d;

	// Filter: change counts only when last two stages agree
	always_comb begin
		s_d = s_q;
		s_d.st = {s_q.st[1:0], pin};
		if (s_q.st[2] == s_q.st[1]) begin
			s_d.lvl = s_q.st[2];
		end
	end

	// Idle high for both select and clock pins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{st: 3'h7, lvl: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.lvl;
endmodule

// ---- design/odl_loader.sv ----
`timescale 1ns/1ps
module odl_loader
	import odl_pkg::*;
#(
	parameter int NCH = odl_pkg::ODL_NCH
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic chip_sel_n,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic preset_midscale_n,
	input wire logic power_down_n,
	output logic [NCH*odl_pkg::ODL_DATA_W-1:0] dac_codes,
	output logic outputs_active,
	output logic load_pulse
);
	import odl_pkg::*;

	typedef struct packed {
		logic [ODL_WORD_W-1:0] shift;
		logic [NCH-1:0][ODL_DATA_W-1:0] hold;
		logic sclk_prev;
		logic csn_prev;
		logic [2:0] sdi_pipe;
		logic load;
	} odl_state_s;

	odl_state_s s_q;
	odl_state_s s_d;
	logic sclk_lvl;
	logic csn_lvl;
	logic sclk_rise;
	logic csn_rise;
	logic [NCH-1:0] sel_onehot;
	logic [NCH*ODL_DATA_W-1:0] chan_mask;

	// Select and clock come from the far side's domain
	odl_sync u_sync_clk (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin(serial_clk),
		.level(sclk_lvl)
	);
	odl_sync u_sync_cs (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin(chip_sel_n),
		.level(csn_lvl)
	);

	// Edge detection on filtered levels
	assign sclk_rise = sclk_lvl && !s_q.sclk_prev;
	assign csn_rise = csn_lvl && !s_q.csn_prev;

	// Address field selects one channel, same number as the address
	function automatic logic [NCH-1:0] odl_decode(input logic [ODL_ADDR_W-1:0] a);
		odl_decode = '0;
		odl_decode[a] = 1'b1;
	endfunction

	// Decoded once; a call result cannot be bit-selected portably
	assign sel_onehot = odl_decode(s_q.shift[ODL_ADDR_HI:ODL_ADDR_LO]);

	// Byte mask of the addressed channel, for the one-channel check
	always_comb begin
		chan_mask = '0;
		for (int i = 0; i < NCH; i++) begin
			chan_mask[i*ODL_DATA_W+:ODL_DATA_W] = {ODL_DATA_W{sel_onehot[i]}};
		end
	end

	// Next state; data pipe matches filter delay of the clock path
	always_comb begin
		s_d = s_q;
		s_d.sclk_prev = sclk_lvl;
		s_d.csn_prev = csn_lvl;
		s_d.sdi_pipe = {s_q.sdi_pipe[1:0], serial_data_in};
		s_d.load = 1'b0;
		if (!csn_lvl && sclk_rise) begin
			// oldest bit falls off the top
			s_d.shift = {s_q.shift[ODL_WORD_W-2:0], s_q.sdi_pipe[2]};
		end
		if (csn_rise) begin
			s_d.load = 1'b1;
			for (int i = 0; i < NCH; i++) begin
				if (sel_onehot[i]) begin
					s_d.hold[i] = s_q.shift[ODL_DATA_HI:ODL_DATA_LO];
				end
			end
		end
	end

	// preset loads midscale asynchronously and clears load; other state holds while it is low
	always_ff @(posedge mclk or negedge arst_n or negedge preset_midscale_n) begin
		if (!arst_n) begin
			s_q <= '{shift: '0, hold: {NCH{ODL_MIDSCALE}}, sclk_prev: 1'b1,
				csn_prev: 1'b1, sdi_pipe: 3'h0, load: 1'b0};
		end else if (!preset_midscale_n) begin
			s_q.hold <= {NCH{ODL_MIDSCALE}};
			s_q.load <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// shutdown only gates outputs, codes kept
	assign dac_codes = s_q.hold;
	assign outputs_active = power_down_n;
	assign load_pulse = s_q.load;

	property p_load_on_cs;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		csn_rise |=> load_pulse;
	endproperty
	a_load_on_cs: assert property (p_load_on_cs) else $error("no load after select");

	property p_idle_hold;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		(csn_lvl && !csn_rise) |=> $stable(dac_codes);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("codes moved while idle");

	// shift register advances on clock rise
	property p_shift;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		(!csn_lvl && sclk_rise) |=> s_q.shift[0] == $past(s_q.sdi_pipe[2]);
	endproperty
	a_shift: assert property (p_shift) else $error("bit not shifted");

	property p_data;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		csn_rise |=> s_q.hold[$past(s_q.shift[ODL_ADDR_HI:ODL_ADDR_LO])]
			== $past(s_q.shift[ODL_DATA_HI:ODL_DATA_LO]);
	endproperty
	a_data: assert property (p_data) else $error("wrong channel data");

	property p_preset;
		@(posedge mclk) disable iff (!arst_n)
		!preset_midscale_n |-> s_q.hold[0] == ODL_MIDSCALE;
	endproperty
	a_preset: assert property (p_preset) else $error("preset not midscale");

	property p_power_down_n;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		(!power_down_n && !csn_rise) |=> $stable(dac_codes);
	endproperty
	a_power_down_n: assert property (p_power_down_n) else $error("codes lost in shutdown");

	property p_noshift;
		@(posedge mclk) disable iff (!arst_n)
		csn_lvl |=> $stable(s_q.shift);
	endproperty
	a_noshift: assert property (p_noshift) else $error("shift while idle");

	property p_one_load;
		@(posedge mclk) disable iff (!arst_n)
		load_pulse |=> !load_pulse;
	endproperty
	a_one_load: assert property (p_one_load) else $error("load longer than a cycle");

	// only the addressed channel may move
	property p_one_channel;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		csn_rise |=> ((dac_codes ^ $past(dac_codes)) & ~$past(chan_mask)) == '0;
	endproperty
	a_one_channel: assert property (p_one_channel) else $error("other channel moved");

	property p_preset_all;
		@(posedge mclk) disable iff (!arst_n)
		!preset_midscale_n |-> dac_codes == {NCH{ODL_MIDSCALE}};
	endproperty
	a_preset_all: assert property (p_preset_all) else $error("preset missed a channel");

	// a load pulse only follows a select rise
	property p_load_cause;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		load_pulse |-> $past(csn_rise);
	endproperty
	a_load_cause: assert property (p_load_cause) else $error("load without select rise");

	// codes change only with a load or a midscale preset
	property p_codes_on_load;
		@(posedge mclk) disable iff (!arst_n || !preset_midscale_n)
		$changed(dac_codes) |-> load_pulse;
	endproperty
	a_codes_on_load: assert property (p_codes_on_load) else $error("codes moved without load");

	// whole word moves up one place per clock rise
	property p_shift_body;
		@(posedge mclk) disable iff (!arst_n)
		(!csn_lvl && sclk_rise) |=> s_q.shift[ODL_WORD_W-1:1] == $past(s_q.shift[ODL_WORD_W-2:0]);
	endproperty
	a_shift_body: assert property (p_shift_body) else $error("shift register misaligned");

	property p_sclk_idle;
		@(posedge mclk) disable iff (!arst_n)
		!sclk_rise |=> $stable(s_q.shift);
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("shift without clock rise");
endmodule

// ---- testbench/odl_host.sv ----
`timescale 1ns/1ps
// Behavioural serial controller on the far side of the loader
module odl_host (
	output logic chip_sel_n,
	output logic serial_clk,
	output logic serial_data_in
);
	// Idle: select high, clock parked high
	initial begin
		chip_sel_n = 1'b1;
		serial_clk = 1'b1;
		serial_data_in = 1'b0;
	end
	task automatic send(input logic [15:0] w, input int n, input logic sel);
		chip_sel_n = !sel;
		#800;
		for (int i = n - 1; i >= 0; i--) begin
			serial_clk = 1'b0;
			serial_data_in = w[i];
			#400;
			serial_clk = 1'b1;
			#400;
		end
		serial_data_in = !serial_data_in; // Hold over, stale value gone
		#400;
		chip_sel_n = 1'b1;
		#800;
	endtask
endmodule

// ---- testbench/odl_loader_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module odl_loader_tb;
	import odl_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic preset_midscale_n = 1'b1;
	logic power_down_n = 1'b1;
	logic chip_sel_n;
	logic serial_clk;
	logic serial_data_in;
	logic [63:0] dac_codes;
	logic outputs_active;
	logic load_pulse;
	logic [7:0] exp_q [8];
	int err_total = 0;
	int checked = 0;
	int pulses = 0;
	always #50 mclk = ~mclk;
	always @(posedge mclk) if (load_pulse === 1'b1) pulses++;
	odl_host host (.chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
		.serial_data_in(serial_data_in));
	odl_loader dut (.mclk(mclk), .arst_n(arst_n), .chip_sel_n(chip_sel_n),
		.serial_clk(serial_clk), .serial_data_in(serial_data_in),
		.preset_midscale_n(preset_midscale_n), .power_down_n(power_down_n),
		.dac_codes(dac_codes), .outputs_active(outputs_active), .load_pulse(load_pulse));
	task automatic stop_test;
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Channel addressed by bits 10 to 8 of a word
	function automatic int chan_of(input logic [15:0] w);
		return int'(w[ODL_ADDR_HI:ODL_ADDR_LO]);
	endfunction
	// One frame, then every channel against the model
	task automatic xfer(input logic [15:0] w, input int n, input logic sel);
		int p = pulses;
		@(posedge mclk);
		#10;
		host.send(w, n, sel);
		if (sel) exp_q[chan_of(w)] = w[ODL_DATA_HI:ODL_DATA_LO];
		`CHK(pulses, p + int'(sel))
		for (int k = 0; k < 8; k++) `CHK(dac_codes[8*k+:8], exp_q[k])
	endtask
	// Hang guard
	initial begin
		#3000000;
		err_total++;
		stop_test;
	end
	initial begin
		int n;
		void'($urandom(32'hEF34));
		for (int k = 0; k < 8; k++) exp_q[k] = ODL_MIDSCALE;
		repeat (16) @(posedge mclk);
		#10 arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		xfer(16'h07FF, 11, 1'b0);
		for (int a = 0; a < 8; a++) xfer({5'h00, a[2:0], 8'(a * 37 + 1)}, 11, 1'b1);
		// extra leading bits dropped, random lengths
		for (int i = 0; i < 14; i++) begin
			n = 11 + ($urandom % 6);
			xfer(16'($urandom), n, 1'b1);
		end
		// shutdown keeps codes, loads still land
		@(posedge mclk);
		#10 power_down_n = 1'b0;
		xfer(16'h05A5, 16, 1'b1);
		`CHK(outputs_active, 1'b0)
		power_down_n = 1'b1;
		xfer(16'h0000, 11, 1'b0);
		`CHK(outputs_active, 1'b1)
		preset_midscale_n = 1'b0;
		#30;
		for (int k = 0; k < 8; k++) `CHK(dac_codes[8*k+:8], ODL_MIDSCALE)
		for (int k = 0; k < 8; k++) exp_q[k] = ODL_MIDSCALE;
		#1000 preset_midscale_n = 1'b1;
		xfer(16'h03C3, 11, 1'b1);
		stop_test;
	end
endmodule
